// *** pkg/pmc_pkg.sv ***
// constants, field positions and state type for the power-mode clock controller
package pmc_pkg;
    // control register 0 layout
    localparam logic [7:0] CTL0_RESET = 8'h48;
    localparam int CO_SEL_LO = 0;
    localparam int CO_SEL_HI = 1;
    localparam int WAIT_PCS_BIT = 2;
    localparam int SUB_DRIVE_BIT = 3;
    localparam int SUB_PORT_BIT = 4;
    localparam int MAIN_STOP_BIT = 5;
    localparam int DIV0_BIT = 6;
    localparam int SRC_SEL_BIT = 7;
    // control register 1 layout
    localparam logic [7:0] CTL1_RESET = 8'h20;
    localparam logic [7:0] CTL1_WMASK = 8'hE1;
    localparam int ALL_STOP_BIT = 0;
    localparam int MAIN_DRIVE_BIT = 5;
    localparam int DIV_LO_BIT = 6;
    localparam int DIV_HI_BIT = 7;
    // clock output selections
    localparam logic [1:0] CO_PORT = 2'h0;
    localparam logic [1:0] CO_SUB = 2'h1;
    localparam logic [1:0] CO_F8 = 2'h2;
    localparam logic [1:0] CO_F32 = 2'h3;
    // division ratios as powers of two
    localparam logic [2:0] LOG_DIV1 = 3'h0;
    localparam logic [2:0] LOG_DIV2 = 3'h1;
    localparam logic [2:0] LOG_DIV4 = 3'h2;
    localparam logic [2:0] LOG_DIV8 = 3'h3;
    localparam logic [2:0] LOG_DIV16 = 3'h4;
    localparam logic [2:0] LOG_DIV32 = 3'h5;
    localparam int CNT_W = 5;
    // peripheral prescaler taps
    localparam int F8_TAP = 2;
    localparam int F32_TAP = 4;
    localparam logic [2:0] F8_LAST = 3'h7;
    localparam logic [4:0] F32_LAST = 5'h1F;
    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_WAIT,
        PMC_STOP
    } pmc_mode_e;
endpackage : pmc_pkg

// *** rtl/pmc_div.sv ***
// programmable power-of-two divider producing a one-cycle tick
`timescale 1ns/10ps
`default_nettype none
module pmc_div (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic step,
    input wire logic [2:0] ratio_log2,
    output logic tick
);
    logic [pmc_pkg::CNT_W-1:0] cnt;
    logic [pmc_pkg::CNT_W-1:0] limit;
    logic [pmc_pkg::CNT_W:0] one_shl;

    assign one_shl = (pmc_pkg::CNT_W+1)'(1) << ratio_log2;
    assign limit = pmc_pkg::CNT_W'(one_shl - (pmc_pkg::CNT_W+1)'(1));
    // counter past the limit after a ratio change ticks at the next step and restarts from zero
    assign tick = step && (cnt >= limit);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (tick) begin
            cnt <= '0;
        end else if (step) begin
            cnt <= cnt + pmc_pkg::CNT_W'(1);
        end
    end
endmodule : pmc_div
`default_nettype wire

// *** rtl/pmc_top.sv ***
// power-mode and bus clock controller: stop, wait, clock select and pins
// Function
// - writing one to the all-clock stop bit halts oscillators, enters stop
// - stop halts bus, peripheral, sub-clock derived and converter clocks
// - in stop only externally clocked timers and serial channels may run
// - stop ends on reset or enabled interrupt, then the handler runs
// - reset or stop entry from main clock sets divide select bit zero
// - stop, expansion mode: bus held, strobes, hold ack, bus clock high
// - stop, single-chip: ports hold; clock pin high for sub, else holds
// - wait instruction halts bus clock and watchdog, oscillators run
// - wait with peripheral stop bit set also gates peripheral clocks
// - wait ends on reset or interrupt, resuming on the same clock source
// - wait, expansion mode: bus held, strobes high, ports unchanged
// - wait, single-chip: clock pin runs unless divided main and stop bit
// - after reset the bus clock is the main clock divided by eight
// - main modes divide the main clock by 1, 2, 4, 8 or 16
// - low-speed mode uses the sub-clock undivided as bus clock
// - source bit picks sub; else bit zero forces eight; else the field
// - clock register writes take effect only while protect is enabled
// - wait peripheral stop control is bit two of register zero
`timescale 1ns/10ps
`default_nettype none
module pmc_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sub_clock_in,
    input wire logic ctl0_wr,
    input wire logic [7:0] ctl0_wdata,
    input wire logic ctl1_wr,
    input wire logic [7:0] ctl1_wdata,
    input wire logic protect_enable,
    input wire logic wait_exec,
    input wire logic irq_request,
    input wire logic irq_enabled,
    input wire logic mem_expansion,
    output logic [7:0] ctl0_rd,
    output logic [7:0] ctl1_rd,
    output logic stop_mode,
    output logic wait_mode,
    output logic run_isr,
    output logic main_osc_enable,
    output logic sub_osc_enable,
    output logic bus_clk_en,
    output logic periph_clk_en,
    output logic periph_div8_en,
    output logic periph_div32_en,
    output logic converter_clk_en,
    output logic watchdog_clk_en,
    output logic sub_clock_en,
    output logic sub_clock_div32_en,
    output logic external_clock_only,
    output logic hold_bus_state,
    output logic bus_strobes_high,
    output logic bus_clock_pin,
    output logic port_hold,
    output logic clock_output_pin,
    output logic clock_output_active
);
    pmc_pkg::pmc_mode_e mode;
    pmc_pkg::pmc_mode_e next_mode;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] next_ctl0;
    logic [7:0] next_ctl1;
    logic sub_sync1;
    logic sub_sync2;
    logic sub_prev;
    logic [4:0] pre_cnt;

    // ratio of the main-clock divider for the bus clock
    function automatic logic [2:0] main_ratio(input logic div0,
                                               input logic [1:0] field);
        logic [2:0] r;
        r = pmc_pkg::LOG_DIV8;
        if (!div0) begin
            case (field)
                2'h0: r = pmc_pkg::LOG_DIV1;
                2'h1: r = pmc_pkg::LOG_DIV2;
                2'h2: r = pmc_pkg::LOG_DIV4;
                2'h3: r = pmc_pkg::LOG_DIV16;
                default: r = pmc_pkg::LOG_DIV8;
            endcase
        end
        return r;
    endfunction : main_ratio

    wire in_run = (mode == pmc_pkg::PMC_RUN);
    wire in_wait = (mode == pmc_pkg::PMC_WAIT);
    wire in_stop = (mode == pmc_pkg::PMC_STOP);
    wire wake = irq_request && irq_enabled;
    wire single_chip = !mem_expansion;
    wire sel_sub = ctl0[pmc_pkg::SRC_SEL_BIT];
    wire wait_pstop = ctl0[pmc_pkg::WAIT_PCS_BIT];
    wire [1:0] co_sel = ctl0[pmc_pkg::CO_SEL_HI:pmc_pkg::CO_SEL_LO];
    wire [1:0] div_field = {ctl1[pmc_pkg::DIV_HI_BIT],
                            ctl1[pmc_pkg::DIV_LO_BIT]};

    // writes only land while protected writes are open and the core runs;
    // the core is halted in wait and stop, so the source stays frozen there
    wire wr0_ok = ctl0_wr && protect_enable && in_run;
    wire wr1_ok = ctl1_wr && protect_enable && in_run;
    wire stop_req = wr1_ok && ctl1_wdata[pmc_pkg::ALL_STOP_BIT];
    wire wait_req = wait_exec && in_run && !stop_req;

    // oscillators: both halted in stop, main also by its own stop bit
    wire main_on = !in_stop && !ctl0[pmc_pkg::MAIN_STOP_BIT];
    wire sub_on = !in_stop && ctl0[pmc_pkg::SUB_PORT_BIT];
    wire sub_edge = sub_sync2 && !sub_prev && sub_on;

    // peripheral clocks run in run, and in wait unless gated off
    wire periph_run = main_on &&
                      (in_run || (in_wait && !wait_pstop));
    wire f8_tick = periph_run && (pre_cnt[2:0] == pmc_pkg::F8_LAST);
    wire f32_tick = periph_run && (pre_cnt == pmc_pkg::F32_LAST);

    // sub-clock derivatives survive wait regardless of the gate bit
    wire sub32_step = sub_edge && !in_stop;
    wire sub32_tick;

    // bus clock source: sub-clock undivided, else divided main clock
    wire [2:0] bus_ratio = sel_sub ? pmc_pkg::LOG_DIV1 :
                           main_ratio(ctl0[pmc_pkg::DIV0_BIT],
                                      div_field);
    wire bus_step = in_run && (sel_sub ? sub_edge : main_on);
    wire bus_tick;

    pmc_div u_bus_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .step(bus_step),
        .ratio_log2(bus_ratio),
        .tick(bus_tick)
    );

    pmc_div u_sub32_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .step(sub32_step),
        .ratio_log2(pmc_pkg::LOG_DIV32),
        .tick(sub32_tick)
    );

    // mode sequencing
    always_comb begin
        next_mode = mode;
        case (mode)
            pmc_pkg::PMC_RUN: begin
                if (stop_req) begin
                    next_mode = pmc_pkg::PMC_STOP;
                end else if (wait_req) begin
                    next_mode = pmc_pkg::PMC_WAIT;
                end
            end
            pmc_pkg::PMC_WAIT: begin
                if (wake) begin
                    next_mode = pmc_pkg::PMC_RUN;
                end
            end
            pmc_pkg::PMC_STOP: begin
                if (wake) begin
                    next_mode = pmc_pkg::PMC_RUN;
                end
            end
            default: next_mode = pmc_pkg::PMC_RUN;
        endcase
    end

    // register updates, including side effects of stop entry and exit
    always_comb begin
        next_ctl0 = ctl0;
        next_ctl1 = ctl1;
        if (wr0_ok) begin
            next_ctl0 = ctl0_wdata;
        end
        if (wr1_ok) begin
            // reserved bits always hold zero
            next_ctl1 = ctl1_wdata & pmc_pkg::CTL1_WMASK;
        end
        if (stop_req) begin
            next_ctl0[pmc_pkg::SUB_DRIVE_BIT] = 1'b1;
            if (!sel_sub) begin
                // entry from high or medium speed forces divide by eight
                next_ctl0[pmc_pkg::DIV0_BIT] = 1'b1;
                next_ctl1[pmc_pkg::MAIN_DRIVE_BIT] = 1'b1;
            end
        end
        if (in_stop && wake) begin
            next_ctl1[pmc_pkg::ALL_STOP_BIT] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= pmc_pkg::PMC_RUN;
            ctl0 <= pmc_pkg::CTL0_RESET;
            ctl1 <= pmc_pkg::CTL1_RESET;
        end else begin
            mode <= next_mode;
            ctl0 <= next_ctl0;
            ctl1 <= next_ctl1;
        end
    end

    // sub-clock pin is asynchronous: two stages, then edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sub_sync1 <= 1'b0;
            sub_sync2 <= 1'b0;
            sub_prev <= 1'b0;
        end else begin
            sub_sync1 <= sub_clock_in;
            sub_sync2 <= sub_sync1;
            sub_prev <= sub_sync2;
        end
    end

    // prescaler freezes when gated, so divided main levels hold
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= '0;
        end else if (periph_run) begin
            pre_cnt <= pre_cnt + 5'h01;
        end
    end

    // clock output pin level
    logic next_clk_out;
    logic next_co_active;
    always_comb begin
        next_clk_out = 1'b0;
        next_co_active = single_chip && (co_sel != pmc_pkg::CO_PORT);
        case (co_sel)
            pmc_pkg::CO_SUB: begin
                if (in_stop) begin
                    next_clk_out = 1'b1;
                end else begin
                    next_clk_out = sub_sync2;
                end
            end
            // counter taps hold their level whenever the prescaler freezes
            pmc_pkg::CO_F8: begin
                next_clk_out = pre_cnt[pmc_pkg::F8_TAP];
            end
            pmc_pkg::CO_F32: next_clk_out = pre_cnt[pmc_pkg::F32_TAP];
            default: next_clk_out = 1'b0;
        endcase
        if (!next_co_active) begin
            next_clk_out = 1'b0;
        end
    end

    // bus clock pin toggles once per bus tick, parks high when halted
    logic next_bus_pin;
    assign next_bus_pin = !in_run ? 1'b1 :
                          (bus_tick ? !bus_clock_pin : bus_clock_pin);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clock_output_pin <= 1'b0;
            clock_output_active <= 1'b0;
            bus_clock_pin <= 1'b1;
        end else begin
            clock_output_pin <= next_clk_out;
            clock_output_active <= next_co_active;
            bus_clock_pin <= next_bus_pin;
        end
    end

    // clock enables toward the rest of the chip
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            periph_div8_en <= 1'b0;
            periph_div32_en <= 1'b0;
            converter_clk_en <= 1'b0;
            watchdog_clk_en <= 1'b0;
            sub_clock_en <= 1'b0;
            sub_clock_div32_en <= 1'b0;
        end else begin
            bus_clk_en <= bus_tick;
            periph_clk_en <= periph_run;
            periph_div8_en <= f8_tick;
            periph_div32_en <= f32_tick;
            converter_clk_en <= periph_run;
            watchdog_clk_en <= in_run && (main_on || sub_on);
            sub_clock_en <= sub_edge && !in_stop;
            sub_clock_div32_en <= sub32_tick;
        end
    end

    // mode flags and pin conditioning
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
            run_isr <= 1'b0;
            main_osc_enable <= 1'b1;
            sub_osc_enable <= 1'b0;
            external_clock_only <= 1'b0;
            hold_bus_state <= 1'b0;
            bus_strobes_high <= 1'b0;
            port_hold <= 1'b0;
        end else begin
            stop_mode <= in_stop;
            wait_mode <= in_wait;
            run_isr <= !in_run && wake;
            main_osc_enable <= main_on;
            sub_osc_enable <= sub_on;
            external_clock_only <= in_stop;
            hold_bus_state <= !in_run && mem_expansion;
            bus_strobes_high <= !in_run && mem_expansion;
            port_hold <= !in_run;
        end
    end

    assign ctl0_rd = ctl0;
    assign ctl1_rd = ctl1;
endmodule : pmc_top
`default_nettype wire

// *** tb/pmc_checker.sv ***
// port-level assertions for the power-mode clock controller
`timescale 1ns/10ps
`default_nettype none
module pmc_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ctl0_wr,
    input wire logic ctl1_wr,
    input wire logic [7:0] ctl1_wdata,
    input wire logic protect_enable,
    input wire logic wait_exec,
    input wire logic irq_request,
    input wire logic irq_enabled,
    input wire logic mem_expansion,
    input wire logic [7:0] ctl0_rd,
    input wire logic [7:0] ctl1_rd,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic run_isr,
    input wire logic main_osc_enable,
    input wire logic bus_clk_en,
    input wire logic periph_clk_en,
    input wire logic watchdog_clk_en,
    input wire logic external_clock_only,
    input wire logic bus_strobes_high,
    input wire logic bus_clock_pin,
    input wire logic clock_output_pin
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // outputs lag the internal mode by a cycle, so run is judged on both
    sequence s_stop_wr;
        ctl1_wr && ctl1_wdata[0] && protect_enable && !stop_mode
            && !wait_mode && !run_isr;
    endsequence
    sequence s_wake;
        (stop_mode || wait_mode) && irq_request && irq_enabled && !run_isr;
    endsequence
    a_stop_entry: assert property (s_stop_wr |-> ##2 stop_mode)
        else $error("stop mode not entered");
    a_div_set: assert property (s_stop_wr ##0 !ctl0_rd[7]
        |=> ctl0_rd[6]) else $error("divide bit zero not set");
    a_div_keep: assert property (s_stop_wr ##0 ctl0_rd[7]
        |=> $stable(ctl0_rd[6])) else $error("divide bit zero changed");
    a_stop_quiet: assert property (stop_mode |-> !bus_clk_en
        && !periph_clk_en && !watchdog_clk_en && !main_osc_enable
        && external_clock_only) else $error("clock running in stop");
    a_wake_isr: assert property (s_wake
        |=> run_isr && !ctl1_rd[0]) else $error("wake did not start handler");
    a_wait_entry: assert property (wait_exec && !stop_mode && !wait_mode
        && !(ctl1_wr && ctl1_wdata[0] && protect_enable) |-> ##2 wait_mode)
        else $error("wait mode not entered");
    a_wait_halt: assert property (wait_mode |-> !bus_clk_en
        && !watchdog_clk_en && main_osc_enable) else $error("wait clocks");
    a_wait_gate: assert property (wait_mode && ctl0_rd[2]
        |-> !periph_clk_en) else $error("peripheral clock not gated");
    a_park_high: assert property ((stop_mode || wait_mode)
        && mem_expansion |-> bus_strobes_high && bus_clock_pin)
        else $error("bus pins not parked high");
    a_clock_output_pin_sub: assert property (stop_mode && !mem_expansion
        && ctl0_rd[1:0] == pmc_pkg::CO_SUB |-> clock_output_pin)
        else $error("clock pin not high in stop");
    a_clock_output_pin_hold: assert property (wait_mode && ctl0_rd[2]
        && ctl0_rd[1] && !run_isr |=> $stable(clock_output_pin))
        else $error("clock pin not frozen in wait");
    a_write_lock: assert property (ctl0_wr && !protect_enable
        && !ctl1_wr |=> $stable(ctl0_rd)) else $error("locked write landed");
endmodule : pmc_checker
bind pmc_top pmc_checker pmc_checker_inst (
    .mclk(mclk), .rst_n(rst_n), .ctl0_wr(ctl0_wr), .ctl1_wr(ctl1_wr),
    .ctl1_wdata(ctl1_wdata), .protect_enable(protect_enable),
    .wait_exec(wait_exec), .irq_request(irq_request),
    .irq_enabled(irq_enabled), .mem_expansion(mem_expansion),
    .ctl0_rd(ctl0_rd), .ctl1_rd(ctl1_rd), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .run_isr(run_isr),
    .main_osc_enable(main_osc_enable), .bus_clk_en(bus_clk_en),
    .periph_clk_en(periph_clk_en), .watchdog_clk_en(watchdog_clk_en),
    .external_clock_only(external_clock_only),
    .bus_strobes_high(bus_strobes_high), .bus_clock_pin(bus_clock_pin),
    .clock_output_pin(clock_output_pin)
);
`default_nettype wire

// *** tb/pmc_core_model.sv ***
// behavioural core: register writes, wait instruction and interrupts
`timescale 1ns/10ps
`default_nettype none
module pmc_core_model (
    input wire logic mclk,
    output logic ctl0_wr,
    output logic [7:0] ctl0_wdata,
    output logic ctl1_wr,
    output logic [7:0] ctl1_wdata,
    output logic protect_enable,
    output logic wait_exec,
    output logic irq_request,
    output logic irq_enabled
);
    initial begin
        {ctl0_wr, ctl1_wr, protect_enable, wait_exec} = 4'h0;
        {irq_request, irq_enabled} = 2'h0;
        {ctl0_wdata, ctl1_wdata} = 16'h0000;
    end
    // protect never clears itself, so software drops it after each write
    task wr(input logic sel, input logic [7:0] d, input logic prot);
        @(negedge mclk);
        protect_enable = prot;
        ctl0_wr = !sel;
        ctl1_wr = sel;
        ctl0_wdata = d;
        ctl1_wdata = d;
        @(negedge mclk);
        {ctl0_wr, ctl1_wr, protect_enable} = 3'h0;
        ctl0_wdata = ~d;
        ctl1_wdata = ~d;
    endtask : wr
    // oscillator settle time, shortened from seconds to cycles
    task settle(input int n);
        repeat (n) @(negedge mclk);
    endtask : settle
    task wait_i();
        @(negedge mclk);
        wait_exec = 1'b1;
        @(negedge mclk);
        wait_exec = 1'b0;
    endtask : wait_i
    // the enable is set a cycle ahead of the request
    task irq(input logic en);
        @(negedge mclk);
        irq_enabled = en;
        @(negedge mclk);
        irq_request = 1'b1;
        @(negedge mclk);
        irq_request = 1'b0;
        irq_enabled = 1'b0;
    endtask : irq
endmodule : pmc_core_model
`default_nettype wire

// *** tb/test_pmc_top.sv ***
// self-checking bench for the power-mode clock controller
`timescale 1ns/10ps
`default_nettype none
module test_pmc_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sub_clock_in = 1'b0;
    logic mem_expansion = 1'b0;
    logic [7:0] ctl0_wdata, ctl1_wdata, ctl0_rd, ctl1_rd;
    logic ctl0_wr, ctl1_wr, protect_enable, wait_exec, irq_request;
    logic irq_enabled, stop_mode, wait_mode, run_isr, main_osc_enable;
    logic sub_osc_enable, bus_clk_en, periph_clk_en, periph_div8_en;
    logic periph_div32_en, converter_clk_en, watchdog_clk_en, sub_clock_en;
    logic sub_clock_div32_en, external_clock_only, hold_bus_state;
    logic bus_strobes_high, bus_clock_pin, port_hold, clock_output_pin;
    logic clock_output_active;
    int n_mismatch = 0;
    int checks = 0;
    always #2.5 mclk = ~mclk;
    // sub-clock rising edge every 16 main cycles, on main falling edges
    always #40 sub_clock_in = ~sub_clock_in;
    pmc_core_model pmc_core_model_inst (
        .mclk(mclk), .ctl0_wr(ctl0_wr), .ctl0_wdata(ctl0_wdata),
        .ctl1_wr(ctl1_wr), .ctl1_wdata(ctl1_wdata),
        .protect_enable(protect_enable), .wait_exec(wait_exec),
        .irq_request(irq_request), .irq_enabled(irq_enabled));
    pmc_top pmc_top_inst (
        .mclk(mclk), .rst_n(rst_n), .sub_clock_in(sub_clock_in),
        .ctl0_wr(ctl0_wr), .ctl0_wdata(ctl0_wdata), .ctl1_wr(ctl1_wr),
        .ctl1_wdata(ctl1_wdata), .protect_enable(protect_enable),
        .wait_exec(wait_exec), .irq_request(irq_request),
        .irq_enabled(irq_enabled), .mem_expansion(mem_expansion),
        .ctl0_rd(ctl0_rd), .ctl1_rd(ctl1_rd), .stop_mode(stop_mode),
        .wait_mode(wait_mode), .run_isr(run_isr),
        .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
        .bus_clk_en(bus_clk_en), .periph_clk_en(periph_clk_en),
        .periph_div8_en(periph_div8_en), .periph_div32_en(periph_div32_en),
        .converter_clk_en(converter_clk_en),
        .watchdog_clk_en(watchdog_clk_en), .sub_clock_en(sub_clock_en),
        .sub_clock_div32_en(sub_clock_div32_en),
        .external_clock_only(external_clock_only),
        .hold_bus_state(hold_bus_state), .bus_strobes_high(bus_strobes_high),
        .bus_clock_pin(bus_clock_pin), .port_hold(port_hold),
        .clock_output_pin(clock_output_pin),
        .clock_output_active(clock_output_active));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask : chk
    // first gap after a ratio change may be short, so the second is judged
    task per(input int exp);
        int p;
        repeat (2) begin
            p = 0;
            while (bus_clk_en !== 1'b1 && p < 200) begin
                @(negedge mclk);
                p++;
            end
            p = 0;
            do begin
                @(negedge mclk);
                p++;
            end while (bus_clk_en !== 1'b1 && p < 200);
        end
        chk(p, exp);
    endtask : per
    task t_reset();
        chk(ctl0_rd, pmc_pkg::CTL0_RESET);
        chk(ctl1_rd, pmc_pkg::CTL1_RESET);
        per(8);
    endtask : t_reset
    task t_div();
        int ratio[4];
        ratio = '{1, 2, 4, 16};
        pmc_core_model_inst.wr(1'b0, 8'h08, 1'b1);
        for (int k = 0; k < 4; k++) begin
            pmc_core_model_inst.wr(1'b1, {k[1:0], 6'h00}, 1'b1);
            per(ratio[k]);
        end
        pmc_core_model_inst.wr(1'b0, 8'h48, 1'b1);
        per(8);
        pmc_core_model_inst.wr(1'b0, 8'h01, 1'b0);
        chk(ctl0_rd, 8'h48);
        pmc_core_model_inst.wr(1'b1, 8'h00, 1'b0);
        chk(ctl1_rd, 8'hC0);
    endtask : t_div
    task t_stop_main();
        pmc_core_model_inst.wr(1'b0, 8'h01, 1'b1);
        pmc_core_model_inst.wr(1'b1, 8'h41, 1'b1);
        repeat (2) @(negedge mclk);
        chk(stop_mode, 1'b1);
        chk(main_osc_enable, 1'b0);
        chk(ctl0_rd[6], 1'b1);
        chk(clock_output_pin, 1'b1);
        chk(port_hold, 1'b1);
        chk(bus_clk_en | periph_clk_en | converter_clk_en, 1'b0);
        pmc_core_model_inst.irq(1'b0);
        chk(stop_mode, 1'b1);
        pmc_core_model_inst.irq(1'b1);
        chk(run_isr, 1'b1);
        chk(ctl1_rd[0], 1'b0);
        per(8);
    endtask : t_stop_main
    task t_stop_low();
        int ns;
        int n32;
        pmc_core_model_inst.wr(1'b0, 8'h10, 1'b1);
        pmc_core_model_inst.settle(30);
        pmc_core_model_inst.wr(1'b0, 8'h90, 1'b1);
        per(16);
        chk(sub_osc_enable, 1'b1);
        // 512 cycles hold exactly 32 sub-clock edges
        ns = 0;
        n32 = 0;
        repeat (512) begin
            @(negedge mclk);
            ns += int'(sub_clock_en);
            n32 += int'(sub_clock_div32_en);
        end
        chk(ns, 32);
        chk(n32, 1);
        mem_expansion = 1'b1;
        pmc_core_model_inst.wr(1'b1, 8'h01, 1'b1);
        repeat (2) @(negedge mclk);
        chk(ctl0_rd[6], 1'b0);
        chk(bus_strobes_high & hold_bus_state & bus_clock_pin, 1'b1);
        chk(external_clock_only, 1'b1);
        chk(sub_osc_enable | sub_clock_en, 1'b0);
        pmc_core_model_inst.irq(1'b1);
        repeat (3) @(negedge mclk);
        mem_expansion = 1'b0;
        chk(stop_mode, 1'b0);
        pmc_core_model_inst.settle(30);
    endtask : t_stop_low
    task t_wait(input logic [7:0] c0, input logic ex, input int pe);
        logic pin;
        logic last;
        int tg;
        int n32;
        mem_expansion = ex;
        pmc_core_model_inst.wr(1'b0, c0, 1'b1);
        per(pe);
        pmc_core_model_inst.wait_i();
        repeat (2) @(negedge mclk);
        chk(wait_mode, 1'b1);
        chk(bus_clk_en | watchdog_clk_en | !main_osc_enable, 1'b0);
        chk((periph_clk_en | periph_div8_en) & c0[2], 1'b0);
        chk(periph_clk_en, !c0[2]);
        chk(bus_strobes_high & hold_bus_state, ex);
        chk(port_hold, 1'b1);
        chk(clock_output_active, !ex && c0[1:0] != 2'h0);
        pin = clock_output_pin;
        last = pin;
        tg = 0;
        n32 = 0;
        repeat (40) begin
            @(negedge mclk);
            tg += int'(clock_output_pin !== last);
            last = clock_output_pin;
            n32 += int'(periph_div32_en);
        end
        chk(clock_output_pin, pin);
        chk(tg != 0, !ex && c0[1:0] != 2'h0 && !(c0[1] && c0[2]));
        chk(n32 != 0, !c0[2]);
        pmc_core_model_inst.irq(1'b1);
        chk(run_isr, 1'b1);
        per(pe);
    endtask : t_wait
    task test_done();
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        t_reset();
        t_div();
        t_stop_main();
        t_stop_low();
        t_wait(8'h06, 1'b0, 1);
        t_wait(8'h40, 1'b1, 8);
        t_wait(8'h42, 1'b0, 8);
        test_done();
    end
endmodule : test_pmc_top
`default_nettype wire
